// ===== rtl/mfp_pkg.sv
package mfp_pkg;
  // register addresses on the device register port
  localparam logic [7:0] ADDR_COMPARATOR_STATUS = 8'h23;
  localparam logic [7:0] ADDR_PIN_CFG = 8'h24;
  localparam logic [15:0] PIN_CFG_RESET = 16'h0000;
  // pin_function_config field positions
  localparam int FILTER_BIT = 15;
  localparam int HOLD_EN_BIT = 14;
  localparam int DRIVE_BIT = 13;
  localparam int OSEL_LO = 9;
  localparam int MASK_LO = 5;
  localparam int FUNC_LO = 1;
  localparam int SENSE_BIT = 0;
  // comparator_status field positions
  localparam int SHDN_FLAG_BIT = 8;
  localparam int WIN_LO = 4;
  localparam int CMP_LO = 0;
  // output select codes
  localparam logic [3:0] OSEL_STORE = 4'h1;
  localparam logic [3:0] OSEL_BUSY0 = 4'h4;
  localparam logic [3:0] OSEL_BUSY3 = 4'h7;
  localparam logic [3:0] OSEL_WIN0 = 4'h8;
  localparam logic [3:0] OSEL_WIN3 = 4'hB;
  // input function codes
  localparam logic [3:0] FN_HOLD = 4'h0;
  localparam logic [3:0] FN_FAULT = 4'h2;
  localparam logic [3:0] FN_CURRENT_OUTPUT = 4'h3;
  localparam logic [3:0] FN_VOLTAGE_OUTPUT = 4'h4;
  localparam logic [3:0] FN_SHDN = 4'h5;
  localparam logic [3:0] FN_CLEAR = 4'h7;
  localparam logic [3:0] FN_LOAD = 4'h8;
  localparam logic [3:0] FN_WAVE = 4'h9;
  localparam logic [3:0] FN_MARGIN = 4'hA;
  localparam logic [3:0] FN_RESET = 4'hB;
  localparam logic [3:0] FN_NVM = 4'hC;
  localparam logic [3:0] FN_LOCK = 4'hD;
  // safe-shutdown policy encodings
  typedef enum logic [1:0] {
    SHDN_HIZ = 2'h0,
    SHDN_NVM_HIZ = 2'h1,
    SHDN_MLO_HIZ = 2'h2,
    SHDN_MHI_HIZ = 2'h3
  } mfp_shdn_t;
  // glitch filter settle time
  localparam int FILT_NS = 50;
  localparam int CLK_NS = 10;
  localparam int FILT_CYCLES = (FILT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] FILT_ONE = 4'h1;
  typedef struct packed {
    logic pin_s1;
    logic pin_s2;
    logic pin_f;
    logic pin_prev;
    logic [3:0] filt_cnt;
    logic [3:0] cmp_s1;
    logic [3:0] cmp_s2;
    logic [3:0] win_lat;
    logic [15:0] cfg;
    logic shdn_flag;
    logic [15:0] rdata;
    logic pin_o;
    logic pin_oe_b;
    logic hold;
    logic fault;
    logic out_clr;
    logic dev_rst;
    logic nvm_ok;
    logic lock;
    logic shdn_req;
    mfp_shdn_t shdn_mode;
    logic [3:0] current_output_off;
    logic [3:0] voltage_output_off;
    logic [3:0] load;
    logic [3:0] wave_start;
    logic [3:0] wave_stop;
    logic [3:0] mar_lo;
    logic [3:0] mar_hi;
  } mfp_state_t;
  localparam mfp_state_t STATE_RESET = '{pin_oe_b: 1'b1, nvm_ok: 1'b1, shdn_mode: SHDN_HIZ, default: '0};
endpackage

// ===== rtl/mfp_top.sv
// Overview of operation
// - shutdown flag sets on shutdown start, clears when status is read
// - window bits show per-channel result, latched or live per latch enable
// - comparator bits show comparator outputs after two-flop synchronisation
// - filter bit selects glitch-filtered pin input, else raw synchronised input
// - low-power hold allowed only while its enable bit is set
// - pin driven only while drive bit is one
// - output select routes store busy, channel busy or window result
// - channel mask gives one enable bit per channel
// - global functions act device-wide, channel ones on masked channels only
// - code 0000: fall enters low-power hold, rise leaves it
// - code 0010: fall starts fault dump
// - code 0011: fall powers down current output, rise powers up
// - code 0100: fall powers down voltage output, rise powers up
// - code 0101: fall starts safe shutdown
// - code 0111: clear held while pin is low
// - code 1000: fall loads masked channels with synchronous update set
// - code 1001: fall stops waveform, rise starts it
// - code 1010: fall triggers margin low, rise margin high
// - code 1011: fall resets device, rise releases; caller pulses pin
// - code 1100: fall permits storage writes, rise blocks them
// - code 1101: fall unlocks register writes, rise locks them
// - pin acts as input only while sense bit is one
// - shutdown carries the configured policy encoding to the output stage
module mfp_top #(
  parameter int unsigned FILT_LEN = mfp_pkg::FILT_CYCLES
) (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  output logic [15:0] REG_RDATA,
  input wire logic PIN_I,
  output logic PIN_O,
  output logic PIN_OE_B,
  input wire logic [3:0] CMP_RAW,
  input wire logic [3:0] WIN_RAW,
  input wire logic [3:0] WIN_CLR,
  input wire logic WIN_LATCH_EN,
  input wire logic STORE_BUSY,
  input wire logic [3:0] CH_BUSY,
  input wire logic [3:0] SYNC_UPD_CFG,
  input wire logic [1:0] SHDN_POLICY,
  output logic LOWPWR_HOLD,
  output logic FAULT_DUMP,
  output logic [3:0] CURRENT_OUTPUT_OFF,
  output logic [3:0] VOLTAGE_OUTPUT_OFF,
  output logic SHDN_REQ,
  output logic [1:0] SHDN_MODE,
  output logic OUTPUT_CLEAR,
  output logic [3:0] LOAD_OUTPUTS,
  output logic [3:0] WAVE_START,
  output logic [3:0] WAVE_STOP,
  output logic [3:0] MARGIN_LO,
  output logic [3:0] MARGIN_HI,
  output logic DEV_RESET,
  output logic NVM_WRITE_OK,
  output logic REG_LOCK
);
  mfp_pkg::mfp_state_t q, n;
  logic pin_in, fall, rise;
  logic [3:0] func, chm, osel, win_now;

  // set wins over clear so an edge in the same cycle is kept
  function automatic logic [3:0] mask_upd(input logic [3:0] cur, input logic [3:0] m,
                                          input logic set, input logic clr);
    mask_upd = set ? (cur | m) : (clr ? (cur & ~m) : cur);
  endfunction

  // output status selection; invalid codes drive low
  function automatic logic out_pick(input logic [3:0] s, input logic st, input logic [3:0] busy,
                                    input logic [3:0] win);
    out_pick = 1'b0;
    if (s == mfp_pkg::OSEL_STORE) begin
      out_pick = st;
    end else if (s >= mfp_pkg::OSEL_BUSY0 && s <= mfp_pkg::OSEL_BUSY3) begin
      out_pick = busy[s[1:0]];
    end else if (s >= mfp_pkg::OSEL_WIN0 && s <= mfp_pkg::OSEL_WIN3) begin
      out_pick = win[s[1:0]];
    end
  endfunction

  // config fields and pin edge terms
  assign func = q.cfg[mfp_pkg::FUNC_LO +: 4];
  assign chm = q.cfg[mfp_pkg::MASK_LO +: 4];
  assign osel = q.cfg[mfp_pkg::OSEL_LO +: 4];
  assign pin_in = q.cfg[mfp_pkg::FILTER_BIT] ? q.pin_f : q.pin_s2;
  assign fall = q.cfg[mfp_pkg::SENSE_BIT] & q.pin_prev & ~pin_in;
  assign rise = q.cfg[mfp_pkg::SENSE_BIT] & ~q.pin_prev & pin_in;
  assign win_now = WIN_LATCH_EN ? q.win_lat : WIN_RAW;

  // next-state logic
  always_comb begin
    n = q;
    n.fault = 1'b0;
    n.shdn_req = 1'b0;
    n.out_clr = 1'b0;
    n.load = 4'h0;
    n.wave_start = 4'h0;
    n.wave_stop = 4'h0;
    n.mar_lo = 4'h0;
    n.mar_hi = 4'h0;
    n.pin_s1 = PIN_I;
    n.pin_s2 = q.pin_s1;
    n.cmp_s1 = CMP_RAW;
    n.cmp_s2 = q.cmp_s1;
    n.win_lat = (q.win_lat & ~WIN_CLR) | WIN_RAW;
    // glitch filter needs a stable run
    if (q.pin_s2 == q.pin_f) begin
      n.filt_cnt = 4'h0;
    end else if (q.filt_cnt >= FILT_LEN[3:0] - mfp_pkg::FILT_ONE) begin
      n.filt_cnt = 4'h0;
      n.pin_f = q.pin_s2;
    end else begin
      n.filt_cnt = q.filt_cnt + mfp_pkg::FILT_ONE;
    end
    n.pin_prev = pin_in;
    // register write, refused while map is locked
    if (REG_WR && REG_ADDR == mfp_pkg::ADDR_PIN_CFG && !q.lock) begin
      n.cfg = REG_WDATA;
    end
    // read data and read side effects
    if (REG_RD) begin
      unique case (REG_ADDR)
        mfp_pkg::ADDR_PIN_CFG: n.rdata = q.cfg;
        mfp_pkg::ADDR_COMPARATOR_STATUS: n.rdata = {7'h00, q.shdn_flag, win_now, q.cmp_s2};
        default: n.rdata = 16'h0000;
      endcase
      if (REG_ADDR == mfp_pkg::ADDR_COMPARATOR_STATUS) begin
        n.shdn_flag = 1'b0;
      end
    end
    // input functions, unlisted codes do nothing
    unique case (func)
      mfp_pkg::FN_HOLD: begin
        if (fall) n.hold = 1'b1;
        if (rise) n.hold = 1'b0;
      end
      mfp_pkg::FN_FAULT: n.fault = fall;
      mfp_pkg::FN_CURRENT_OUTPUT: n.current_output_off = mask_upd(q.current_output_off, chm, fall, rise);
      mfp_pkg::FN_VOLTAGE_OUTPUT: n.voltage_output_off = mask_upd(q.voltage_output_off, chm, fall, rise);
      mfp_pkg::FN_SHDN: begin
        if (fall) begin
          n.shdn_req = 1'b1;
          n.shdn_flag = 1'b1;
          n.shdn_mode = mfp_pkg::mfp_shdn_t'(SHDN_POLICY);
        end
      end
      mfp_pkg::FN_CLEAR: n.out_clr = q.cfg[mfp_pkg::SENSE_BIT] & ~pin_in;
      mfp_pkg::FN_LOAD: n.load = fall ? (chm & SYNC_UPD_CFG) : 4'h0;
      mfp_pkg::FN_WAVE: begin
        n.wave_stop = fall ? chm : 4'h0;
        n.wave_start = rise ? chm : 4'h0;
      end
      mfp_pkg::FN_MARGIN: begin
        n.mar_lo = fall ? chm : 4'h0;
        n.mar_hi = rise ? chm : 4'h0;
      end
      mfp_pkg::FN_RESET: begin
        if (fall) n.dev_rst = 1'b1;
        if (rise) n.dev_rst = 1'b0;
      end
      mfp_pkg::FN_NVM: begin
        if (fall) n.nvm_ok = 1'b1;
        if (rise) n.nvm_ok = 1'b0;
      end
      mfp_pkg::FN_LOCK: begin
        if (fall) n.lock = 1'b0;
        if (rise) n.lock = 1'b1;
      end
      default: begin
      end
    endcase
    // hold forced off when not allowed
    if (!q.cfg[mfp_pkg::HOLD_EN_BIT]) begin
      n.hold = 1'b0;
    end
    n.pin_oe_b = ~q.cfg[mfp_pkg::DRIVE_BIT];
    n.pin_o = q.cfg[mfp_pkg::DRIVE_BIT] & out_pick(osel, STORE_BUSY, CH_BUSY, win_now);
  end

  // state register
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      q <= mfp_pkg::STATE_RESET;
    end else begin
      q <= n;
    end
  end

  // outputs straight from flops
  assign REG_RDATA = q.rdata;
  assign PIN_O = q.pin_o;
  assign PIN_OE_B = q.pin_oe_b;
  assign LOWPWR_HOLD = q.hold;
  assign FAULT_DUMP = q.fault;
  assign CURRENT_OUTPUT_OFF = q.current_output_off;
  assign VOLTAGE_OUTPUT_OFF = q.voltage_output_off;
  assign SHDN_REQ = q.shdn_req;
  assign SHDN_MODE = q.shdn_mode;
  assign OUTPUT_CLEAR = q.out_clr;
  assign LOAD_OUTPUTS = q.load;
  assign WAVE_START = q.wave_start;
  assign WAVE_STOP = q.wave_stop;
  assign MARGIN_LO = q.mar_lo;
  assign MARGIN_HI = q.mar_hi;
  assign DEV_RESET = q.dev_rst;
  assign NVM_WRITE_OK = q.nvm_ok;
  assign REG_LOCK = q.lock;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);

  property p_flag_read_clear;
    REG_RD && REG_ADDR == mfp_pkg::ADDR_COMPARATOR_STATUS && !(fall && func == mfp_pkg::FN_SHDN) |=> !q.shdn_flag;
  endproperty
  a_flag_read_clear: assert property (p_flag_read_clear) else $error("shutdown flag not cleared by read");

  property p_shdn_start;
    fall && func == mfp_pkg::FN_SHDN |=> SHDN_REQ && q.shdn_flag && SHDN_MODE == $past(SHDN_POLICY);
  endproperty
  a_shdn_start: assert property (p_shdn_start) else $error("shutdown not started on falling edge");

  property p_win_live;
    !WIN_LATCH_EN && REG_RD && REG_ADDR == mfp_pkg::ADDR_COMPARATOR_STATUS
      |=> REG_RDATA[mfp_pkg::WIN_LO +: 4] == $past(WIN_RAW);
  endproperty
  a_win_live: assert property (p_win_live) else $error("live window bits wrong");

  property p_cmp_sync;
    REG_RD && REG_ADDR == mfp_pkg::ADDR_COMPARATOR_STATUS |=> REG_RDATA[mfp_pkg::CMP_LO +: 4] == $past(CMP_RAW, 3);
  endproperty
  a_cmp_sync: assert property (p_cmp_sync) else $error("comparator bits not two-flop delayed");

  property p_drive;
    REG_WR && REG_ADDR == mfp_pkg::ADDR_PIN_CFG && !q.lock
      |=> ##1 PIN_OE_B == !$past(REG_WDATA[mfp_pkg::DRIVE_BIT], 2);
  endproperty
  a_drive: assert property (p_drive) else $error("pin enable does not follow drive bit");

  property p_hold_enter;
    fall && func == mfp_pkg::FN_HOLD && q.cfg[mfp_pkg::HOLD_EN_BIT] |=> LOWPWR_HOLD;
  endproperty
  a_hold_enter: assert property (p_hold_enter) else $error("hold not entered");

  property p_current_output_off;
    fall && func == mfp_pkg::FN_CURRENT_OUTPUT |=> (CURRENT_OUTPUT_OFF & $past(chm)) == $past(chm);
  endproperty
  a_current_output_off: assert property (p_current_output_off) else $error("current output not powered down");

  property p_clear_low;
    func == mfp_pkg::FN_CLEAR && q.cfg[mfp_pkg::SENSE_BIT] && !pin_in |=> OUTPUT_CLEAR;
  endproperty
  a_clear_low: assert property (p_clear_low) else $error("clear not held while pin low");

  property p_load;
    fall && func == mfp_pkg::FN_LOAD |=> LOAD_OUTPUTS == $past(chm & SYNC_UPD_CFG);
  endproperty
  a_load: assert property (p_load) else $error("load pulse wrong");

  property p_lock;
    q.lock && REG_WR |=> $stable(q.cfg);
  endproperty
  a_lock: assert property (p_lock) else $error("write accepted while locked");

  property p_sense_off;
    !q.cfg[mfp_pkg::SENSE_BIT] |=> !FAULT_DUMP && !SHDN_REQ && LOAD_OUTPUTS == 4'h0;
  endproperty
  a_sense_off: assert property (p_sense_off) else $error("action while input disabled");

  property p_flag_read_value;
    REG_RD && REG_ADDR == mfp_pkg::ADDR_COMPARATOR_STATUS |=> REG_RDATA[mfp_pkg::SHDN_FLAG_BIT] == $past(q.shdn_flag);
  endproperty
  a_flag_read_value: assert property (p_flag_read_value) else $error("shutdown flag read wrong");

  property p_nvm_permit;
    (fall || rise) && func == mfp_pkg::FN_NVM |=> NVM_WRITE_OK == $past(fall);
  endproperty
  a_nvm_permit: assert property (p_nvm_permit) else $error("storage permit does not follow pin");

  property p_wave_start;
    rise && func == mfp_pkg::FN_WAVE |=> WAVE_START == $past(chm) && WAVE_STOP == 4'h0;
  endproperty
  a_wave_start: assert property (p_wave_start) else $error("waveform start pulse wrong");
endmodule

// ===== bench/mfp_pin_drv.sv
module mfp_pin_drv (
  input wire logic clk,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // controller parks the pin high between actions
  initial pin = 1'b1;
  // whole-cycle pulses
  // caller sits just after an edge, so each level stands exactly n cycles
  task automatic drive(input logic v, input int n);
    pin <= v;
    repeat (n) @(posedge clk);
  endtask
endmodule

// ===== bench/mfp_top_test.sv
module mfp_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic SYS_CLK = 0, RST_B = 0, REG_WR = 0, REG_RD = 0, WIN_LATCH_EN = 0, STORE_BUSY = 0;
  logic [7:0] REG_ADDR = 0;
  logic [15:0] REG_WDATA = 0, REG_RDATA, d;
  logic [3:0] CMP_RAW = 0, WIN_RAW = 0, WIN_CLR = 0, CH_BUSY = 0, SYNC_UPD_CFG = 0;
  logic [1:0] SHDN_POLICY = 0, SHDN_MODE, pol;
  logic PIN_O, PIN_OE_B, LOWPWR_HOLD, FAULT_DUMP, SHDN_REQ, OUTPUT_CLEAR, DEV_RESET, NVM_WRITE_OK, REG_LOCK;
  logic [3:0] CURRENT_OUTPUT_OFF, VOLTAGE_OUTPUT_OFF, LOAD_OUTPUTS, WAVE_START, WAVE_STOP, MARGIN_LO, MARGIN_HI;
  wire logic PIN_I;
  logic rd_d = 0, ev_clr = 0;
  logic [21:0] ev_acc = 0;
  int shdn_n = 0, n_fail = 0, checks_done = 0;
  logic [15:0] exp_q [$];
  wire logic [12:0] lv = {LOWPWR_HOLD, CURRENT_OUTPUT_OFF, VOLTAGE_OUTPUT_OFF, OUTPUT_CLEAR, DEV_RESET, NVM_WRITE_OK, REG_LOCK};
  wire logic [21:0] ev = {FAULT_DUMP, SHDN_REQ, LOAD_OUTPUTS, WAVE_START, WAVE_STOP, MARGIN_LO, MARGIN_HI};
  logic [3:0] fc [13] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'h1, 4'hC, 4'hD};
  logic [12:0] lf [13] = '{13'h1002, 13'h0002, 13'h0502, 13'h0052, 13'h0002, 13'h000A, 13'h0002,
    13'h0002, 13'h0002, 13'h0006, 13'h0002, 13'h0002, 13'h0000};
  logic [12:0] lr [13] = '{13'h0002, 13'h0002, 13'h0002, 13'h0002, 13'h0002, 13'h0002, 13'h0002,
    13'h0002, 13'h0002, 13'h0002, 13'h0002, 13'h0000, 13'h0001};
  logic [21:0] ee [13] = '{22'h0, 22'h200000, 22'h0, 22'h0, 22'h100000, 22'h0, 22'h010000,
    22'h005500, 22'h000055, 22'h0, 22'h0, 22'h0, 22'h0};

  mfp_top #(.FILT_LEN(2)) mfp_top_inst (
    .SYS_CLK(SYS_CLK),
    .RST_B(RST_B),
    .REG_WR(REG_WR),
    .REG_RD(REG_RD),
    .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA),
    .REG_RDATA(REG_RDATA),
    .PIN_I(PIN_I),
    .PIN_O(PIN_O),
    .PIN_OE_B(PIN_OE_B),
    .CMP_RAW(CMP_RAW),
    .WIN_RAW(WIN_RAW),
    .WIN_CLR(WIN_CLR),
    .WIN_LATCH_EN(WIN_LATCH_EN),
    .STORE_BUSY(STORE_BUSY),
    .CH_BUSY(CH_BUSY),
    .SYNC_UPD_CFG(SYNC_UPD_CFG),
    .SHDN_POLICY(SHDN_POLICY),
    .LOWPWR_HOLD(LOWPWR_HOLD),
    .FAULT_DUMP(FAULT_DUMP),
    .CURRENT_OUTPUT_OFF(CURRENT_OUTPUT_OFF),
    .VOLTAGE_OUTPUT_OFF(VOLTAGE_OUTPUT_OFF),
    .SHDN_REQ(SHDN_REQ),
    .SHDN_MODE(SHDN_MODE),
    .OUTPUT_CLEAR(OUTPUT_CLEAR),
    .LOAD_OUTPUTS(LOAD_OUTPUTS),
    .WAVE_START(WAVE_START),
    .WAVE_STOP(WAVE_STOP),
    .MARGIN_LO(MARGIN_LO),
    .MARGIN_HI(MARGIN_HI),
    .DEV_RESET(DEV_RESET),
    .NVM_WRITE_OK(NVM_WRITE_OK),
    .REG_LOCK(REG_LOCK)
  );
  mfp_pin_drv mfp_pin_drv_inst (.clk(SYS_CLK), .pin(PIN_I));

  initial forever #5 SYS_CLK = ~SYS_CLK;

  task automatic fail(input string m);
    n_fail++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic chk_rd(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) fail($sformatf("read %h exp %h", g, e));
  endtask
  task automatic chk_pin(input logic [1:0] g, input logic [1:0] e);
    checks_done++;
    if (g !== e) fail($sformatf("pin %b exp %b", g, e));
  endtask
  task automatic chk_act(input logic [21:0] g, input logic [21:0] e, input string m);
    checks_done++;
    if (g !== e) fail($sformatf("%s %h exp %h", m, g, e));
  endtask
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge SYS_CLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= v;
    @(posedge SYS_CLK);
    REG_WR <= 1'b0;
  endtask
  // read notes its expectation; the monitor below compares it
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge SYS_CLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    exp_q.push_back(e);
    @(posedge SYS_CLK);
    REG_RD <= 1'b0;
    repeat (2) @(posedge SYS_CLK);
  endtask
  task automatic clr_ev();
    ev_clr <= 1'b1;
    @(posedge SYS_CLK);
    ev_clr <= 1'b0;
  endtask
  function automatic logic sel(input int c);
    if (c == 1) return STORE_BUSY;
    if (c >= 4 && c <= 7) return CH_BUSY[c-4];
    if (c >= 8 && c <= 11) return WIN_RAW[c-8];
    return 1'b0;
  endfunction
  // sense on, hold allowed, filter on, channels 0 and 2
  function automatic logic [15:0] cfg(input logic [3:0] c);
    return {11'h605, c, 1'b1};
  endfunction

  // read data is sampled one edge after the taking edge, where it stands
  always @(posedge SYS_CLK) begin
    rd_d <= REG_RD;
    ev_acc <= ev_clr ? 22'h0 : ev_acc | ev;
    shdn_n <= ev_clr ? 0 : shdn_n + int'(SHDN_REQ);
    if (rd_d === 1'b1) begin
      if (exp_q.size() == 0) fail("unexpected read");
      else chk_rd(REG_RDATA, exp_q.pop_front());
    end
  end

  // hang guard, far beyond the expected several hundred cycles
  initial begin
    repeat (20000) @(posedge SYS_CLK);
    fail("timeout");
    tally_and_finish();
  end

  initial begin
    void'($urandom(94015));
    repeat (10) @(posedge SYS_CLK);
    RST_B <= 1'b1;
    chk_pin({PIN_OE_B, PIN_O}, 2'h2);
    chk_act({9'h000, lv}, 22'h000002, "reset levels");
    rd(mfp_pkg::ADDR_PIN_CFG, mfp_pkg::PIN_CFG_RESET);
    d = 16'($urandom()) & 16'hFFFE;
    wr(mfp_pkg::ADDR_PIN_CFG, d);
    wr(mfp_pkg::ADDR_COMPARATOR_STATUS, 16'hFFFF);
    rd(mfp_pkg::ADDR_PIN_CFG, d);
    rd(8'h30, 16'h0000);
    CMP_RAW <= 4'($urandom());
    WIN_RAW <= 4'($urandom());
    repeat (4) @(posedge SYS_CLK);
    rd(mfp_pkg::ADDR_COMPARATOR_STATUS, {8'h00, WIN_RAW, CMP_RAW});
    // latches gather hits even while live, so empty them first
    WIN_RAW <= 4'h0;
    WIN_CLR <= 4'hF;
    @(posedge SYS_CLK);
    // latched window: a short hit sticks until cleared
    WIN_CLR <= 4'h0;
    WIN_LATCH_EN <= 1'b1;
    WIN_RAW <= 4'hA;
    @(posedge SYS_CLK);
    WIN_RAW <= 4'h0;
    repeat (4) @(posedge SYS_CLK);
    rd(mfp_pkg::ADDR_COMPARATOR_STATUS, {8'h00, 4'hA, CMP_RAW});
    WIN_CLR <= 4'h2;
    @(posedge SYS_CLK);
    WIN_CLR <= 4'h0;
    repeat (4) @(posedge SYS_CLK);
    rd(mfp_pkg::ADDR_COMPARATOR_STATUS, {8'h00, 4'h8, CMP_RAW});
    WIN_LATCH_EN <= 1'b0;
    // every output select code, invalid ones included
    for (int c = 0; c < 16; c++) begin
      STORE_BUSY <= 1'($urandom());
      CH_BUSY <= 4'($urandom());
      WIN_RAW <= 4'($urandom());
      wr(mfp_pkg::ADDR_PIN_CFG, {3'b001, 4'(c), 9'h000});
      repeat (5) @(posedge SYS_CLK);
      chk_pin({PIN_OE_B, PIN_O}, {1'b0, sel(c)});
    end
    wr(mfp_pkg::ADDR_PIN_CFG, 16'h0000);
    repeat (3) @(posedge SYS_CLK);
    chk_pin({PIN_OE_B, PIN_O}, 2'h2);
    // host sets sync update for channels 0 and 1
    SYNC_UPD_CFG <= 4'h3;
    pol = 2'($urandom());
    SHDN_POLICY <= pol;
    for (int i = 0; i < 13; i++) begin
      wr(mfp_pkg::ADDR_PIN_CFG, cfg(fc[i]));
      clr_ev();
      mfp_pin_drv_inst.drive(1'b0, 12);
      chk_act({9'h000, lv}, {9'h000, lf[i]}, "fall levels");
      if (fc[i] == mfp_pkg::FN_SHDN) begin
        chk_act({20'h0, SHDN_MODE}, {20'h0, pol}, "policy");
        chk_act(22'(shdn_n), 22'h1, "shutdown count");
        rd(mfp_pkg::ADDR_COMPARATOR_STATUS, {7'h00, 1'b1, WIN_RAW, CMP_RAW});
        rd(mfp_pkg::ADDR_COMPARATOR_STATUS, {8'h00, WIN_RAW, CMP_RAW});
      end
      mfp_pin_drv_inst.drive(1'b1, 12);
      chk_act({9'h000, lv}, {9'h000, lr[i]}, "rise levels");
      chk_act(ev_acc, ee[i], "events");
    end
    wr(mfp_pkg::ADDR_PIN_CFG, 16'h0000);
    rd(mfp_pkg::ADDR_PIN_CFG, cfg(mfp_pkg::FN_LOCK));
    mfp_pin_drv_inst.drive(1'b0, 12);
    chk_act({21'h0, REG_LOCK}, 22'h0, "unlock");
    wr(mfp_pkg::ADDR_PIN_CFG, cfg(mfp_pkg::FN_HOLD) & 16'hBFFF);
    mfp_pin_drv_inst.drive(1'b1, 12);
    mfp_pin_drv_inst.drive(1'b0, 12);
    chk_act({21'h0, LOWPWR_HOLD}, 22'h0, "hold off");
    // one-cycle glitch must not pass the filter, nor a pulse with sense off
    wr(mfp_pkg::ADDR_PIN_CFG, cfg(mfp_pkg::FN_SHDN));
    mfp_pin_drv_inst.drive(1'b1, 12);
    clr_ev();
    mfp_pin_drv_inst.drive(1'b0, 1);
    mfp_pin_drv_inst.drive(1'b1, 12);
    wr(mfp_pkg::ADDR_PIN_CFG, cfg(mfp_pkg::FN_SHDN) & 16'hFFFE);
    mfp_pin_drv_inst.drive(1'b0, 12);
    chk_act(22'(shdn_n), 22'h0, "no shutdown");
    // raw path answers by the fifth edge, the filter holds it two edges longer
    mfp_pin_drv_inst.drive(1'b1, 12);
    wr(mfp_pkg::ADDR_PIN_CFG, cfg(mfp_pkg::FN_SHDN) & 16'h7FFF);
    clr_ev();
    mfp_pin_drv_inst.drive(1'b0, 5);
    chk_act(22'(shdn_n), 22'h1, "raw path");
    mfp_pin_drv_inst.drive(1'b1, 12);
    wr(mfp_pkg::ADDR_PIN_CFG, cfg(mfp_pkg::FN_SHDN));
    clr_ev();
    mfp_pin_drv_inst.drive(1'b0, 5);
    chk_act(22'(shdn_n), 22'h0, "filter delay");
    mfp_pin_drv_inst.drive(1'b0, 4);
    chk_act(22'(shdn_n), 22'h1, "filtered path");
    tally_and_finish();
  end
endmodule
